// ---- scwt_map.vh ----
// Constants for the system counter and wakeup timer block
`ifndef SCWT_MAP_VH
`define SCWT_MAP_VH

// Counter geometry
`define SCWT_CNT_W 64
`define SCWT_CNT_MSB 63
`define SCWT_CNT_RST 64'h0000000000000000
`define SCWT_CNT_INC 64'h0000000000000001

// Clock rates in MHz: the counting clock and the least allowed rate
`define SCWT_CLK_MHZ 125
`define SCWT_MIN_MHZ 10

// Cores served by the count broadcast
`define SCWT_NCORE 4
`define SCWT_CORE_MSB 3
`define SCWT_CORE_IDX_W 2

// Set to 1'b1 when every per-core timer is always on
`define SCWT_ALL_AON 1'b0

// Synchroniser vector layout
`define SCWT_SYNC_W 8
`define SCWT_SY_CNT_EN 0
`define SCWT_SY_TON_LO 1
`define SCWT_SY_TON_HI 4
`define SCWT_SY_INTC_OFF 5
`define SCWT_SY_WDOG 6
`define SCWT_SY_WEDGE 7

// Register frame selectors
`define SCWT_FR_W 3
`define SCWT_FR_CTRL 3'h0
`define SCWT_FR_READ 3'h1
`define SCWT_FR_TCTL 3'h2
`define SCWT_FR_VIEW 3'h3
`define SCWT_FR_USER 3'h4
`define SCWT_FR_VOFF 3'h5

// Interrupt classes
`define SCWT_IRQ_SPI 2'h0
`define SCWT_IRQ_SGI 2'h1
`define SCWT_IRQ_PPI 2'h2
`define SCWT_IRQ_LPI 2'h3

`endif

// ---- scwt_sync.v ----
// Two-stage synchroniser for a vector of asynchronous levels
module scwt_sync #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- scwt_top.v ----
// System counter, per-core timers, wakeup timer and wakeup capture
`include "scwt_map.vh"

// Notes on behaviour
// R1: Counter advances on a clock of at least ten megahertz.
// R2: Counter width and rate never wrap within ten years.
// R3: Counter is 56 to 64 bits; full 64 with scaling.
// R4: Count is broadcast to every core whose local timer must run.
// R5: Each core timer holds a compare and raises its private interrupt.
// R6: Wakeup timer exists unless all core timers are always on.
// R7: Wakeup timer expiry raises a shared or locality interrupt.
// R8: No virtual timer or user frame; offset reads zero, ignores writes.
// R9: Wakeup timer frame decodes in non-secure space.
// R10: Control secure; read frame absent; timer control both; view non-secure.
// R11: Wakeup interrupt: enabled, and targeted shared, software, private or locality.
// R12: Core wakes on any wakeup interrupt ignoring masks and priority.
// R13: Power controller can wake on timer or watchdog; interrupt still raised.
// R14: Waking interrupt already pending before control returns to the OS.
// R15: Wakeup interrupt uses the ordinary device to controller path.
// R16: Edge wakeup event is held until woken and delivered.
// R17: Per-core timer state is kept across core power-down.
// R18: Wakeup timer asserts while enabled and count at or past compare.
module scwt_top (
  input wire CLK_SYS,
  input wire RESET,
  input wire CNT_EN,
  output reg [`SCWT_CNT_MSB:0] CNT_VALUE,
  input wire [`SCWT_CORE_MSB:0] CORE_TIMER_ON,
  output reg [`SCWT_CORE_MSB:0] CORE_CNT_VALID,
  input wire [`SCWT_CORE_MSB:0] CORE_CMP_WE,
  input wire [`SCWT_CNT_MSB:0] CORE_CMP_DATA,
  input wire [`SCWT_CORE_MSB:0] CORE_TMR_EN,
  output reg [`SCWT_CORE_MSB:0] CORE_PPI,
  input wire WT_EN,
  input wire WT_CMP_WE,
  input wire [`SCWT_CNT_MSB:0] WT_CMP_DATA,
  input wire WT_LPI_MODE,
  output reg WT_SPI,
  output reg WT_LPI_MSG,
  input wire FRAME_REQ,
  input wire [`SCWT_FR_W-1:0] FRAME_SEL,
  input wire FRAME_NS,
  input wire FRAME_WRITE,
  output reg FRAME_ACK,
  output reg FRAME_GRANT,
  output reg FRAME_RAZ,
  input wire IRQ_VALID,
  input wire [1:0] IRQ_TYPE,
  input wire IRQ_TARGETED,
  input wire IRQ_ENABLED,
  input wire [`SCWT_CORE_IDX_W-1:0] IRQ_CORE,
  output reg [`SCWT_CORE_MSB:0] CORE_WAKE,
  input wire INTC_OFF,
  input wire WDOG_EXPIRE,
  input wire PWRC_WAKE_EN,
  output reg PWRC_WAKE_REQ,
  input wire WAKE_EDGE,
  input wire WAKE_ACK,
  output reg WAKE_IRQ
);

  // Counting clock must meet the least rate
  localparam CLK_OK = (`SCWT_CLK_MHZ >= `SCWT_MIN_MHZ); // [R1]

  wire [`SCWT_SYNC_W-1:0] pins_async;
  wire [`SCWT_SYNC_W-1:0] pins_sync;
  wire cnt_en_s;
  wire [`SCWT_CORE_MSB:0] timer_on_s;
  wire intc_off_s;
  wire wdog_s;
  wire wedge_s;
  wire [`SCWT_CORE_MSB:0] core_on;
  wire [`SCWT_CORE_MSB:0] core_sel;
  wire pwrc_src;

  // Counter state
  reg [`SCWT_CNT_MSB:0] cnt_reg;
  reg [`SCWT_CNT_MSB:0] cnt_next;

  // Wakeup timer state
  reg [`SCWT_CNT_MSB:0] wt_cmp_reg;
  reg wt_hit_reg;
  reg lpi_pend_reg;
  reg lpi_pend_next;

  // Edge wake capture state
  reg wedge_prev_reg;
  reg wake_pend_reg;
  reg wake_pend_next;

  // Decode results
  reg grant_next;
  reg raz_next;
  reg wake_irq_class;

  wire wt_active;
  wire wt_hit;
  wire wt_rise;
  wire lpi_send;
  wire wedge_rise;
  wire wake_taken;

  // Every pin from outside the clock domain crosses here
  assign pins_async = {WAKE_EDGE, WDOG_EXPIRE, INTC_OFF, CORE_TIMER_ON,
                       CNT_EN};

  scwt_sync #(
    .W(`SCWT_SYNC_W)
  ) u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .d(pins_async),
    .q(pins_sync)
  );

  assign cnt_en_s = pins_sync[`SCWT_SY_CNT_EN];
  assign timer_on_s = pins_sync[`SCWT_SY_TON_HI:`SCWT_SY_TON_LO];
  assign intc_off_s = pins_sync[`SCWT_SY_INTC_OFF];
  assign wdog_s = pins_sync[`SCWT_SY_WDOG];
  assign wedge_s = pins_sync[`SCWT_SY_WEDGE];

  // Cores whose local timer runs, and the core named by an interrupt
  assign core_on = timer_on_s | {`SCWT_NCORE{`SCWT_ALL_AON}};
  assign core_sel = {{`SCWT_CORE_MSB{1'b0}}, 1'b1} << IRQ_CORE;

  // Full 64-bit count at 125 MHz lasts far beyond ten years
  always @* begin
    cnt_next = cnt_reg;
    if (cnt_en_s && CLK_OK) begin
      cnt_next = cnt_reg + `SCWT_CNT_INC; // [R1] [R2] [R3]
    end
  end

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      cnt_reg <= `SCWT_CNT_RST;
      CNT_VALUE <= `SCWT_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
      // Broadcast copy always matches the internal count
      CNT_VALUE <= cnt_next; // [R4]
    end
  end

  // Per-core timers; compare values sit in this always-on logic
  genvar gi;
  generate
    for (gi = 0; gi < `SCWT_NCORE; gi = gi + 1) begin : g_core
      reg [`SCWT_CNT_MSB:0] cmp_reg;
      always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          cmp_reg <= `SCWT_CNT_RST;
          CORE_CNT_VALID[gi] <= 1'b0;
          CORE_PPI[gi] <= 1'b0;
          CORE_WAKE[gi] <= 1'b0;
        end else begin
          // Kept across core power-down so firmware need not restore it
          if (CORE_CMP_WE[gi]) begin
            cmp_reg <= CORE_CMP_DATA; // [R17]
          end
          CORE_CNT_VALID[gi] <= core_on[gi]; // [R4]
          CORE_PPI[gi] <= core_on[gi] & CORE_TMR_EN[gi] &
                          (cnt_next >= cmp_reg); // [R5]
          // Masks and priority play no part in the wake decision
          CORE_WAKE[gi] <= wake_irq_class & core_sel[gi]; // [R12]
        end
      end
    end
  endgenerate

  // Wakeup timer
  assign wt_active = WT_EN & ~`SCWT_ALL_AON; // [R6]
  assign wt_hit = wt_active & (cnt_next >= wt_cmp_reg); // [R18]
  assign wt_rise = wt_hit & ~wt_hit_reg;
  // No message interrupts while the controller is powered off
  assign lpi_send = lpi_pend_reg & ~intc_off_s;

  // A new expiry in the send cycle keeps the message pending
  always @* begin
    lpi_pend_next = lpi_pend_reg & ~lpi_send;
    if (wt_rise && WT_LPI_MODE) begin
      lpi_pend_next = 1'b1; // [R7]
    end
  end

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wt_cmp_reg <= `SCWT_CNT_RST;
      wt_hit_reg <= 1'b0;
      lpi_pend_reg <= 1'b0;
      WT_SPI <= 1'b0;
      WT_LPI_MSG <= 1'b0;
    end else begin
      if (WT_CMP_WE) begin
        wt_cmp_reg <= WT_CMP_DATA;
      end
      wt_hit_reg <= wt_hit;
      lpi_pend_reg <= lpi_pend_next;
      // Level stays up while the count is at or past compare
      WT_SPI <= wt_hit & ~WT_LPI_MODE; // [R7] [R18]
      WT_LPI_MSG <= lpi_send; // [R7]
    end
  end

  // Frame access decode; unimplemented frames are refused
  always @* begin
    grant_next = 1'b0;
    raz_next = 1'b0;
    case (FRAME_SEL)
      `SCWT_FR_CTRL: begin
        grant_next = ~FRAME_NS; // [R10]
      end
      `SCWT_FR_READ: begin
        grant_next = 1'b0; // [R10]
      end
      `SCWT_FR_TCTL: begin
        grant_next = 1'b1; // [R10]
      end
      `SCWT_FR_VIEW: begin
        grant_next = FRAME_NS; // [R9] [R10]
      end
      `SCWT_FR_USER: begin
        grant_next = 1'b0; // [R8]
      end
      `SCWT_FR_VOFF: begin
        // Virtual offset reads as zero and drops writes
        grant_next = 1'b1;
        raz_next = 1'b1; // [R8]
      end
      default: begin
        grant_next = 1'b0;
        raz_next = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      FRAME_ACK <= 1'b0;
      FRAME_GRANT <= 1'b0;
      FRAME_RAZ <= 1'b0;
    end else begin
      // Grant and read-as-zero only qualify an acknowledge
      FRAME_ACK <= FRAME_REQ;
      FRAME_GRANT <= FRAME_REQ & grant_next;
      FRAME_RAZ <= FRAME_REQ & raz_next & ~FRAME_WRITE;
    end
  end

  // Wakeup interrupt classification
  always @* begin
    wake_irq_class = 1'b0;
    if (IRQ_VALID && IRQ_ENABLED) begin
      case (IRQ_TYPE)
        `SCWT_IRQ_SPI: begin
          wake_irq_class = IRQ_TARGETED; // [R11]
        end
        `SCWT_IRQ_SGI: begin
          wake_irq_class = 1'b1; // [R11]
        end
        `SCWT_IRQ_PPI: begin
          wake_irq_class = 1'b1; // [R11]
        end
        `SCWT_IRQ_LPI: begin
          wake_irq_class = 1'b1; // [R11]
        end
        default: begin
          wake_irq_class = 1'b0;
        end
      endcase
    end
  end

  // Edge wakeup capture: held until the controller takes it
  assign wedge_rise = wedge_s & ~wedge_prev_reg;
  assign wake_taken = WAKE_ACK & ~intc_off_s & wake_pend_reg;
  // Sources that call the power controller while the controller is off
  assign pwrc_src = wt_hit | wdog_s | wake_pend_next;

  // A new edge in the acknowledge cycle keeps the flag set
  always @* begin
    wake_pend_next = wake_pend_reg & ~wake_taken; // [R14]
    if (wedge_rise) begin
      wake_pend_next = 1'b1; // [R16]
    end
  end

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wedge_prev_reg <= 1'b0;
      wake_pend_reg <= 1'b0;
      WAKE_IRQ <= 1'b0;
      PWRC_WAKE_REQ <= 1'b0;
    end else begin
      wedge_prev_reg <= wedge_s;
      wake_pend_reg <= wake_pend_next;
      // Presented on the normal line once the controller is powered
      WAKE_IRQ <= wake_pend_next & ~intc_off_s; // [R15] [R14]
      // Timer and watchdog interrupts remain raised on their own lines
      PWRC_WAKE_REQ <= intc_off_s & PWRC_WAKE_EN & pwrc_src; // [R13] [R16]
    end
  end

endmodule

// ---- scwt_checker.sv ----
// Assertions on the counter, timers, frame decode and wake ports
module scwt_checker (
  input wire CLK_SYS,
  input wire RESET,
  input wire CNT_EN,
  input wire [63:0] CNT_VALUE,
  input wire [3:0] CORE_TMR_EN,
  input wire [3:0] CORE_PPI,
  input wire WT_EN,
  input wire WT_CMP_WE,
  input wire [63:0] WT_CMP_DATA,
  input wire WT_LPI_MODE,
  input wire WT_SPI,
  input wire FRAME_REQ,
  input wire [2:0] FRAME_SEL,
  input wire FRAME_NS,
  input wire FRAME_ACK,
  input wire FRAME_GRANT,
  input wire IRQ_VALID,
  input wire [1:0] IRQ_TYPE,
  input wire IRQ_TARGETED,
  input wire IRQ_ENABLED,
  input wire [1:0] IRQ_CORE,
  input wire [3:0] CORE_WAKE,
  input wire INTC_OFF,
  input wire WDOG_EXPIRE,
  input wire PWRC_WAKE_EN,
  input wire PWRC_WAKE_REQ,
  input wire WAKE_ACK,
  input wire WAKE_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] up_reg;
  reg [63:0] wcmp_reg;
  reg wset_reg;
  // Shadow of the wakeup compare, and a settle count after reset
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      up_reg <= 3'h0;
      wset_reg <= 1'h0;
      wcmp_reg <= 64'h0;
    end else begin
      if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
      if (WT_CMP_WE) begin
        wset_reg <= 1'h1;
        wcmp_reg <= WT_CMP_DATA;
      end
    end
  end
  wire ready = up_reg == 3'h7;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_bad_frame;
    FRAME_REQ && (FRAME_SEL inside {3'h1, 3'h4, 3'h6, 3'h7} ||
    (FRAME_SEL == 3'h0 && FRAME_NS) || (FRAME_SEL == 3'h3 && !FRAME_NS));
  endsequence
  chk_cnt_step: assert property (
    CNT_EN[*5] ##0 ready |-> CNT_VALUE == $past(CNT_VALUE) + 64'h1)
    else $error("count step wrong");
  chk_ppi_gate: assert property (
    (CORE_PPI & ~$past(CORE_TMR_EN)) == 4'h0) else $error("ppi not gated");
  chk_wt_level: assert property (
    ready && wset_reg && !$past(WT_CMP_WE) |-> WT_SPI ==
    ($past(WT_EN) && !$past(WT_LPI_MODE) && CNT_VALUE >= wcmp_reg))
    else $error("wakeup level wrong");
  chk_ack_pulse: assert property (
    ready |-> FRAME_ACK == $past(FRAME_REQ) && (!FRAME_GRANT || FRAME_ACK))
    else $error("frame ack wrong");
  chk_frame_refuse: assert property (
    s_bad_frame |=> FRAME_ACK && !FRAME_GRANT) else $error("frame granted");
  chk_wake_pulse: assert property (
    IRQ_VALID && IRQ_ENABLED && (IRQ_TYPE != 2'h0 || IRQ_TARGETED) |=>
    CORE_WAKE == 4'h1 << $past(IRQ_CORE)) else $error("core wake wrong");
  chk_wake_hold: assert property (
    (!INTC_OFF)[*4] ##0 WAKE_IRQ && !WAKE_ACK |=> WAKE_IRQ)
    else $error("wake interrupt lost");
  chk_pwrc_wdog: assert property (
    (INTC_OFF && WDOG_EXPIRE && PWRC_WAKE_EN)[*4] |-> PWRC_WAKE_REQ)
    else $error("no power wake");
endmodule

// ---- scwt_intc.sv ----
// Interrupt controller model that takes a wake interrupt after a delay
module scwt_intc #(
  parameter int DLY = 3
) (
  input wire logic clk,
  input wire logic irq,
  input wire logic off,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // Takes the interrupt only while powered, as an ordinary pending line
  always @(negedge clk) begin
    n = (irq && !off && !ack) ? n + 1 : 0;
    ack <= n == DLY;
  end
endmodule

// ---- scwt_top_tb.sv ----
// Self-checking bench for the system counter and wakeup timer
module scwt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'h0, RESET = 1'h1, CNT_EN = 1'h0, WT_EN = 1'h0;
  logic WT_CMP_WE = 1'h0, WT_LPI_MODE = 1'h0, FRAME_REQ = 1'h0;
  logic FRAME_NS = 1'h0, FRAME_WRITE = 1'h0, IRQ_VALID = 1'h0;
  logic IRQ_TARGETED = 1'h0, IRQ_ENABLED = 1'h0, INTC_OFF = 1'h0;
  logic WDOG_EXPIRE = 1'h0, PWRC_WAKE_EN = 1'h0, WAKE_EDGE = 1'h0;
  logic WAKE_ACK, WT_SPI, WT_LPI_MSG, FRAME_ACK, FRAME_GRANT, FRAME_RAZ;
  logic PWRC_WAKE_REQ, WAKE_IRQ;
  logic [3:0] CORE_TIMER_ON = 4'hf, CORE_CMP_WE = 4'h0, CORE_TMR_EN = 4'h0;
  logic [3:0] CORE_CNT_VALID, CORE_PPI, CORE_WAKE;
  logic [63:0] CNT_VALUE, CORE_CMP_DATA = 64'h0, WT_CMP_DATA = 64'h0;
  logic [2:0] FRAME_SEL = 3'h0;
  logic [1:0] IRQ_TYPE = 2'h0, IRQ_CORE = 2'h0;
  int n_mismatch = 0;
  int cmp_count = 0;
  // Row: select, non-secure, write, then expected grant and read-as-zero
  logic [6:0] rows [0:10] = '{7'h02, 7'h08, 7'h18, 7'h22, 7'h2a, 7'h3a,
    7'h30, 7'h48, 7'h5b, 7'h5e, 7'h78};
  scwt_top u_dut (.*);
  scwt_intc u_intc (.clk(CLK_SYS), .irq(WAKE_IRQ), .off(INTC_OFF),
    .ack(WAKE_ACK));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic wait_cnt(input logic [63:0] v);
    for (int i = 0; i < 200 && CNT_VALUE !== v; i++) tick(1);
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #4 CLK_SYS = ~CLK_SYS;
  initial begin
    #20000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    tick(3);
    chk(CNT_VALUE, 64'h0);
    chk({CORE_WAKE, WAKE_IRQ, FRAME_ACK}, 6'h0);
    RESET = 1'h0;
    tick(1);
    foreach (rows[i]) begin
      {FRAME_SEL, FRAME_NS, FRAME_WRITE} = rows[i][6:2];
      FRAME_REQ = 1'h1;
      tick(1);
      chk({FRAME_ACK, FRAME_GRANT, FRAME_RAZ}, {1'h1, rows[i][1:0]});
    end
    FRAME_REQ = 1'h0;
    CNT_EN = 1'h1;
    tick(10);
    chk(CNT_VALUE, 64'h8);
    chk(CORE_CNT_VALID, 4'hf);
    {CORE_CMP_DATA, WT_CMP_DATA} = {64'h20, 64'h20};
    {CORE_CMP_WE, CORE_TMR_EN, WT_CMP_WE, WT_EN} = 10'h047;
    tick(1);
    {CORE_CMP_WE, WT_CMP_WE} = 5'h0;
    wait_cnt(64'h1f);
    chk({CORE_PPI, WT_SPI}, 5'h0);
    tick(1);
    chk({CORE_PPI, WT_SPI}, 5'h3);
    CORE_TIMER_ON = 4'he;
    tick(4);
    chk({CORE_CNT_VALID, CORE_PPI}, 8'he0);
    CORE_TIMER_ON = 4'hf;
    tick(4);
    chk(CORE_PPI, 4'h1);
    {WT_LPI_MODE, WT_CMP_WE, WT_CMP_DATA} = {2'h3, 64'h40};
    tick(1);
    WT_CMP_WE = 1'h0;
    chk(WT_SPI, 1'h0);
    wait_cnt(64'h40);
    chk(WT_LPI_MSG, 1'h0);
    tick(1);
    chk(WT_LPI_MSG, 1'h1);
    tick(1);
    chk(WT_LPI_MSG, 1'h0);
    IRQ_VALID = 1'h1;
    for (int t = 0; t < 5; t++) begin
      {IRQ_ENABLED, IRQ_TYPE} = t < 4 ? {1'h1, t[1:0]} : 3'h1;
      IRQ_CORE = t[1:0];
      tick(1);
      chk(CORE_WAKE, (t % 4 == 0) ? 4'h0 : 4'h1 << t);
    end
    {IRQ_TARGETED, IRQ_ENABLED, IRQ_TYPE, IRQ_CORE} = 6'h30;
    tick(1);
    chk(CORE_WAKE, 4'h1);
    {IRQ_VALID, INTC_OFF, PWRC_WAKE_EN} = 3'h3;
    tick(4);
    chk({PWRC_WAKE_REQ, WAKE_IRQ}, 2'h2);
    WT_EN = 1'h0;
    tick(4);
    chk(PWRC_WAKE_REQ, 1'h0);
    WAKE_EDGE = 1'h1;
    tick(4);
    WAKE_EDGE = 1'h0;
    tick(4);
    chk({PWRC_WAKE_REQ, WAKE_IRQ}, 2'h2);
    INTC_OFF = 1'h0;
    for (int i = 0; i < 20 && WAKE_IRQ !== 1'h1; i++) tick(1);
    chk({PWRC_WAKE_REQ, WAKE_IRQ}, 2'h1);
    for (int i = 0; i < 20 && WAKE_IRQ !== 1'h0; i++) tick(1);
    chk(WAKE_IRQ, 1'h0);
    {INTC_OFF, WDOG_EXPIRE} = 2'h3;
    tick(4);
    chk(PWRC_WAKE_REQ, 1'h1);
    RESET = 1'h1;
    tick(1);
    chk(CNT_VALUE, 64'h0);
    chk({CORE_CNT_VALID, CORE_PPI, WT_SPI, PWRC_WAKE_REQ}, 10'h0);
    RESET = 1'h0;
    tick(1);
    chk(CNT_VALUE, 64'h0);
    tick(3);
    chk(CNT_VALUE, 64'h2);
    end_sim;
  end
endmodule
bind scwt_top scwt_checker u_chk (.*);
